//--- crfb_can_model.sv
// Receiving controller model on the frame link
module crfb_can_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Pacing set by the bench
  input  wire logic [3:0]  stallCyc,
  // Frame from the builder
  input  wire logic        txValid,
  input  wire logic [63:0] txData,
  output logic             txReady,
  // What was received
  output logic [63:0]      rxFrame,
  output logic             rxCrcOk,
  output logic [7:0]       rxCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt;  // Cycles stalled so far
  // Receiver side check byte
  function automatic logic [7:0] crcOf(input logic [55:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 55; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
    end
    return c ^ 8'hFF;
  endfunction
  // Stall, then accept one frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txReady <= 1'b0;
      rxFrame <= 64'h0;
      rxCrcOk <= 1'b0;
      rxCount <= 8'h00;
      waitCnt <= 4'h0;
    end else if (txValid && txReady) begin
      txReady <= 1'b0;
      rxFrame <= txData;
      rxCrcOk <= (crcOf(txData[63:8]) == txData[7:0]);
      rxCount <= rxCount + 8'h01;
      waitCnt <= 4'h0;
    end else if (txValid) begin
      // Hold off ready for stallCyc + 1 cycles of valid
      if (waitCnt >= stallCyc) txReady <= 1'b1;
      else waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

//--- crfb_crc8.sv
// Byte-wide CRC-8 engine for the frame check byte
module crfb_crc8 (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstN,
  input  wire logic       ce,
  // Control
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [7:0] din,
  // Result
  output logic      [7:0] crc
);

  // ***************************************************************
  // One byte step, MSB first
  // ***************************************************************
  function automatic logic [7:0] step(input logic [7:0] s,
                                      input logic [7:0] d);
    logic [7:0] v;
    v = s ^ d;
    for (int i = 0; i < 8; i++) begin
      v = v[7] ? ((v << 1) ^ crfb_pkg::CRC_POLY) : (v << 1);
    end
    return v;
  endfunction

  logic [7:0] crc_r;  // Running remainder
  logic [7:0] crc_nxt;

  // Clear wins over a data step
  assign crc_nxt = clr ? crfb_pkg::CRC_INIT :
                   en  ? step(crc_r, din) : crc_r;

  // Remainder register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) crc_r <= crfb_pkg::CRC_INIT;
    else if (ce) crc_r <= crc_nxt;
  end

  // Final inversion
  assign crc = crc_r ^ crfb_pkg::CRC_XOR;

endmodule

//--- crfb_pkg.sv
// Shared constants for the current report frame builder
package crfb_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int CLK_HZ       = 50_000_000;  // System clock rate
  localparam int PERIOD_MS    = 10;          // Frame period in ms
  localparam int PERIOD_CYC   = CLK_HZ / 1000 * PERIOD_MS;
  localparam int FAULT_REACTION_TIME_MS = 500; // Safe state deadline
  localparam int CNT_W        = 20;          // Period counter width

  // ***************************************************************
  // Register map, byte addresses
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00; // Enable, variant
  localparam logic [7:0] ADDR_STAT   = 8'h04; // Sticky events, W1C
  localparam logic [7:0] ADDR_MASK   = 8'h08; // Interrupt mask
  localparam logic [7:0] ADDR_CANID  = 8'h0C; // Frame identifier
  localparam logic [7:0] ADDR_FRMHI  = 8'h10; // Last frame bytes 0-3
  localparam logic [7:0] ADDR_FRMLO  = 8'h14; // Last frame bytes 4-7
  localparam logic [7:0] ADDR_STATE  = 8'h18; // Live block state

  // Control bits and reset values
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_SAFE_BIT = 1;
  localparam logic [1:0]  CTRL_RST  = 2'h3;
  localparam logic [10:0] CANID_RST = 11'h3C2;

  // Status bits
  localparam int ST_W        = 4;
  localparam int ST_SENT     = 0;  // Frame taken by controller
  localparam int ST_VIOL     = 1;  // Frame carried violation flag
  localparam int ST_IERR     = 2;  // Frame carried internal error
  localparam int ST_OVRUN    = 3;  // Period tick while busy

  // ***************************************************************
  // Frame coding
  // ***************************************************************
  localparam logic [3:0]  DLC_BYTES   = 4'h8;
  localparam int          NUM_BYTES   = 8;
  localparam logic [2:0]  CRC_LAST    = 3'h7;   // Index of check byte
  localparam logic [3:0]  ROLL_MAX    = 4'hF;
  localparam logic [3:0]  ROLL_WRAP   = 4'h1;
  localparam logic [1:0]  SUPPLY_NA   = 2'h3;
  localparam logic [23:0] ANA_ZERO    = 24'h800000;
  localparam logic [23:0] ANA_OVER    = 24'hFFFFFF;
  localparam logic [15:0] DIG_ZERO    = 16'h8000;
  localparam logic [7:0]  CRC_POLY    = 8'h1D;
  localparam logic [7:0]  CRC_INIT    = 8'hFF;
  localparam logic [7:0]  CRC_XOR     = 8'hFF;

  // Thresholds, currents in mA except CLAMP_A in A, supply in mV
  localparam int SUP_MIN_MV   = 7800;
  localparam int SUP_MAX_MV   = 16200;
  localparam int IERR_MA      = 1_600_000;
  localparam int CLAMP_MA     = 1_550_000;
  localparam int CLAMP_A      = 1550;
  localparam int IMAX_MA      = 1_700_000;
  localparam int SG_LOW_MA    = 220_000;
  localparam int SG_HIGH_MA   = 1_500_000;
  localparam int SG_ABS_MA    = 44_000;
  localparam int SG_PCT       = 20;
  localparam int MA_PER_A     = 1000;

  // Sequencer states, Gray except the SEND to IDLE return
  typedef enum logic [1:0] {
    CRFB_IDLE = 2'b00,
    CRFB_CALC = 2'b01,
    CRFB_SEND = 2'b11
  } crfb_state_t;

endpackage

//--- crfb_props.sv
// Checker on the frame builder ports
module crfb_props #(
  parameter int PERIOD_CYC = 40
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Bus answer
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Frame link
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic [3:0]  txDlc,
  input wire logic [63:0] txData
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************************************
  // Helper state
  // ***************************************************************
  logic [3:0] lastRoll_r;  // Counter of the last accepted frame
  logic       seen_r;      // Any frame accepted yet
  // Check byte, MSB first, own copy so a shared slip shows
  function automatic logic [7:0] crcOf(input logic [55:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 55; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
    end
    return c ^ 8'hFF;
  endfunction
  // Last accepted counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lastRoll_r <= 4'h0;
      seen_r     <= 1'b0;
    end else if (txValid && txReady) begin
      lastRoll_r <= txData[63:60];
      seen_r     <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ***************************************************************
  // Properties
  // ***************************************************************
  a_dlc_eight: assert property (txDlc == 4'h8)
    else $error("data length not eight");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_frame_hold: assert property (txValid && !txReady |=>
    txValid && $stable(txData)) else $error("frame dropped or changed");
  a_one_accept: assert property (txValid && txReady |=> !txValid)
    else $error("frame offered twice");
  a_check_byte: assert property (txValid |->
    txData[7:0] == crcOf(txData[63:8])) else $error("bad check byte");
  a_roll_start: assert property ($rose(txValid) && !seen_r |->
    txData[63:60] == 4'h0) else $error("counter not from zero");
  a_roll_step: assert property ($rose(txValid) && seen_r |->
    txData[63:60] == ((lastRoll_r == 4'hF) ? 4'h1 : lastRoll_r + 4'h1))
    else $error("counter step wrong");
  a_ana_clamp: assert property (txValid |->
    (txData[55:32] >= 24'h685950 && txData[55:32] <= 24'h97A6B0) ||
    txData[55:32] == 24'hFFFFFF) else $error("analog out of range");
  a_dig_clamp: assert property (txValid |-> txData[31:16] == 16'h0 ||
    (txData[31:16] >= 16'h79F2 && txData[31:16] <= 16'h860E))
    else $error("digital out of range");
  a_spare_zero: assert property (txValid |-> txData[15:8] == 8'h00)
    else $error("spare byte not zero");
  a_over_ierr: assert property (txValid &&
    txData[55:32] == 24'hFFFFFF |-> txData[57]) else $error("no error flag");
  a_plain_pair: assert property (txValid &&
    txData[31:16] == 16'h0 |-> !txData[56]) else $error("plain flag set");
endmodule
bind crfb_top crfb_props #(.PERIOD_CYC(PERIOD_CYC)) u_props (
  .clk(clk), .arst_n(arst_n), .hreadyout(hreadyout), .hresp(hresp),
  .txValid(txValid), .txReady(txReady), .txDlc(txDlc), .txData(txData));

//--- crfb_top.sv
// Current report frame builder with AHB-Lite register slave
//
// Summary of operation
// - No frames until supply seen in 7.8-16.2 V
// - Internal error flag on hardware fault
// - Internal error flag above 1600 A
// - Violation if over 20% apart, 220-1500 A
// - Violation if over 44 A apart, within 220 A
// - Violation flagged, frames keep going, within 500 ms
// - Analog field 24-bit offset binary, 1 mA steps
// - Analog field clamped at 1550 A with sign
// - Analog field all ones above maximum current
// - Digital field clamped at 1550 A with sign
// - Digital field 16-bit offset binary, 1 A steps
// - Byte 7 is CRC-8 over bytes 0-6
// - Counter from 0, wraps 15 to 1
// - Supply status 11 when no measurement
// - Identifier 3C2, sent every 10 ms
// - Byte 0 holds counter, supply, error, violation
// - Plain variant zeroes bytes 4-6 and violation
// - Big-endian packing, standard frame with 11-bit identifier
module crfb_top #(
  parameter int PERIOD_CYC = crfb_pkg::PERIOD_CYC
) (
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               ce,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // Measurements from on-chip logic
  input  wire logic signed [23:0] anaMa,
  input  wire logic signed [15:0] digAmp,
  input  wire logic [15:0]        supplyMv,
  input  wire logic               supplyMvValid,
  input  wire logic [1:0]         supplyState,
  input  wire logic               hwFault,
  // Frame to CAN controller
  output logic                    txValid,
  input  wire logic               txReady,
  output logic [10:0]             txId,
  output logic [3:0]              txDlc,
  output logic [63:0]             txData,
  // Interrupt
  output logic                    irq
);

  // ***************************************************************
  // Reset release
  // ***************************************************************
  logic rstMeta_r;  // First stage, read only by second
  logic rstN;       // Synchronised reset

  // Asynchronous assert, clocked release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN      <= rstMeta_r;
    end
  end

  // ***************************************************************
  // Register state
  // ***************************************************************
  localparam int CNT_W = crfb_pkg::CNT_W;
  localparam logic [CNT_W-1:0] PER_LAST =
    CNT_W'(PERIOD_CYC - 1);

  logic [1:0]               ctrl_r;   // Enable, safety variant
  logic [crfb_pkg::ST_W-1:0] stat_r;  // Sticky events
  logic [crfb_pkg::ST_W-1:0] mask_r;  // Interrupt mask
  logic [10:0]              canId_r;  // Frame identifier
  logic [63:0]              frame_r;  // Frame being built or sent
  logic [3:0]               roll_r;   // frame_roll_counter
  logic                     startOk_r;// Supply seen in range
  logic                     violSeen_r; // Violation since last build
  logic [CNT_W-1:0]         per_r;    // Period counter
  logic [2:0]               idx_r;    // Byte index during CALC
  crfb_pkg::crfb_state_t    st_r;     // Sequencer state
  crfb_pkg::crfb_state_t    st_nxt;

  wire enable  = ctrl_r[crfb_pkg::CTRL_EN_BIT];
  wire safeVar = ctrl_r[crfb_pkg::CTRL_SAFE_BIT];

  // ***************************************************************
  // Current arithmetic
  // ***************************************************************
  // Wide signed copies so products and sums cannot overflow
  logic signed [31:0] anaW;
  logic signed [31:0] digW;
  logic signed [31:0] diffW;
  logic        [31:0] anaAbs;
  logic        [31:0] diffAbs;

  assign anaW    = 32'(anaMa);
  assign digW    = 32'(digAmp) * crfb_pkg::MA_PER_A;
  assign diffW   = anaW - digW;
  assign anaAbs  = anaW[31] ? 32'(-anaW) : 32'(anaW);
  assign diffAbs = diffW[31] ? 32'(-diffW) : 32'(diffW);

  // Analog field code
  wire anaOverMax = anaAbs > 32'(crfb_pkg::IMAX_MA);
  wire anaClamp   = anaAbs > 32'(crfb_pkg::CLAMP_MA);
  logic signed [31:0] anaLim;
  logic        [23:0] anaCode;

  // Clamp to the limit, keeping the sign
  assign anaLim = !anaClamp ? anaW :
                  anaW[31] ? -32'(crfb_pkg::CLAMP_MA) :
                  32'(crfb_pkg::CLAMP_MA);
  // Offset binary, out of range reads as all ones
  assign anaCode = anaOverMax ? crfb_pkg::ANA_OVER :
                   24'(anaLim) + crfb_pkg::ANA_ZERO;

  // Digital field code
  logic signed [15:0] digLim;
  logic        [15:0] digCode;

  // Clamped also past the maximum, where no value is better
  assign digLim =
    (digAmp >  16'(crfb_pkg::CLAMP_A)) ?  16'(crfb_pkg::CLAMP_A) :
    (digAmp < -16'(crfb_pkg::CLAMP_A)) ? -16'(crfb_pkg::CLAMP_A) :
    digAmp;
  assign digCode = 16'(digLim) + crfb_pkg::DIG_ZERO;

  // ***************************************************************
  // Plausibility and error detection
  // ***************************************************************
  wire bandLow  = anaAbs <= 32'(crfb_pkg::SG_LOW_MA);
  wire bandHigh = !bandLow &&
                  anaAbs <= 32'(crfb_pkg::SG_HIGH_MA);
  // Relative test by multiplication, no divider needed
  wire violHigh = bandHigh &&
                  (diffAbs * 32'd100 >
                   anaAbs * 32'(crfb_pkg::SG_PCT));
  wire violLow  = bandLow &&
                  diffAbs > 32'(crfb_pkg::SG_ABS_MA);
  wire violNow  = safeVar && (violHigh || violLow);

  // Fault or overcurrent raises the error flag
  wire ierrNow  = hwFault ||
                  anaAbs > 32'(crfb_pkg::IERR_MA);

  // Supply in the start-up window
  wire supInRange = supplyMvValid &&
    supplyMv >= 16'(crfb_pkg::SUP_MIN_MV) &&
    supplyMv <= 16'(crfb_pkg::SUP_MAX_MV);

  // Supply status, unknown when no measurement
  wire [1:0] supField = supplyMvValid ? supplyState :
                        crfb_pkg::SUPPLY_NA;

  // ***************************************************************
  // Frame assembly
  // ***************************************************************
  // Byte 0 to byte 6, byte 0 in the top bits, check byte zero
  logic [7:0]  byte0;
  logic [63:0] frameNew;

  assign byte0 = {roll_r, supField, ierrNow,
                  safeVar & (violNow | violSeen_r)};
  // Violation captured over the period, flagged next frame
  assign frameNew = {byte0, anaCode,
                     safeVar ? digCode : 16'h0000,
                     8'h00, 8'h00};

  // ***************************************************************
  // Period timer and sequencer
  // ***************************************************************
  wire tick     = per_r == PER_LAST;
  wire txDone   = txValid && txReady;
  wire startReq = tick && enable && startOk_r &&
                  st_r == crfb_pkg::CRFB_IDLE;
  wire calcEnd  = st_r == crfb_pkg::CRFB_CALC &&
                  idx_r == crfb_pkg::CRC_LAST;
  wire [7:0] curByte = frame_r[63 - 8 * idx_r -: 8];
  wire [7:0] crcOut;

  // Next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      crfb_pkg::CRFB_IDLE: if (startReq) st_nxt = crfb_pkg::CRFB_CALC;
      crfb_pkg::CRFB_CALC: if (calcEnd) st_nxt = crfb_pkg::CRFB_SEND;
      crfb_pkg::CRFB_SEND: if (txDone) st_nxt = crfb_pkg::CRFB_IDLE;
      default:             st_nxt = crfb_pkg::CRFB_IDLE;
    endcase
  end

  // Free-running period counter
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) per_r <= '0;
    else if (ce) per_r <= tick ? '0 : per_r + 1'b1;
  end

  // State and byte index
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st_r  <= crfb_pkg::CRFB_IDLE;
      idx_r <= '0;
    end else if (ce) begin
      st_r  <= st_nxt;
      idx_r <= (st_r == crfb_pkg::CRFB_CALC) ? idx_r + 1'b1 : '0;
    end
  end

  // Frame register: load on start, check byte at end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) frame_r <= '0;
    else if (ce) begin
      if (startReq) frame_r <= frameNew;
      else if (calcEnd) frame_r[7:0] <= crcOut;
    end
  end

  // CRC over bytes 0 to 6 while the index walks
  crfb_crc8 uCrc (
    .clk  (clk),
    .rstN (rstN),
    .ce   (ce),
    .clr  (startReq),
    .en   (st_r == crfb_pkg::CRFB_CALC && !calcEnd),
    .din  (curByte),
    .crc  (crcOut)
  );

  // Counter steps after each frame taken, skipping zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) roll_r <= '0;
    else if (ce && txDone) begin
      roll_r <= (roll_r == crfb_pkg::ROLL_MAX) ?
                crfb_pkg::ROLL_WRAP : roll_r + 1'b1;
    end
  end

  // Start-up gate, released once supply is in range
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) startOk_r <= 1'b0;
    else if (ce && supInRange) startOk_r <= 1'b1;
  end

  // Violation memory; a new event wins over the clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) violSeen_r <= 1'b0;
    else if (ce) violSeen_r <= violNow ||
                               (violSeen_r && !startReq);
  end

  // ***************************************************************
  // Frame outputs
  // ***************************************************************
  // Frames keep flowing while the violation flag is up
  assign txValid = st_r == crfb_pkg::CRFB_SEND;
  assign txId    = canId_r;
  assign txDlc   = crfb_pkg::DLC_BYTES;
  assign txData  = frame_r;

  // ***************************************************************
  // AHB-Lite slave
  // ***************************************************************
  logic       wrPend_r;  // Write data phase pending
  logic [7:0] wrAddr_r;  // Write address
  logic [31:0] rdata_r;  // Read data for the data phase

  wire addrPh = hsel && htrans[1] && hready;
  wire wrPh   = wrPend_r;
  wire wrCtrl = wrPh && wrAddr_r == crfb_pkg::ADDR_CTRL;
  wire wrStat = wrPh && wrAddr_r == crfb_pkg::ADDR_STAT;
  wire wrMask = wrPh && wrAddr_r == crfb_pkg::ADDR_MASK;
  wire wrId   = wrPh && wrAddr_r == crfb_pkg::ADDR_CANID;

  // Read mux on the address phase; unmapped reads as zero
  logic [31:0] rdMux;
  wire [7:0] ra = haddr[7:0];
  assign rdMux =
    (ra == crfb_pkg::ADDR_CTRL)  ? {30'h0, ctrl_r} :
    (ra == crfb_pkg::ADDR_STAT)  ? {28'h0, stat_r} :
    (ra == crfb_pkg::ADDR_MASK)  ? {28'h0, mask_r} :
    (ra == crfb_pkg::ADDR_CANID) ? {21'h0, canId_r} :
    (ra == crfb_pkg::ADDR_FRMHI) ? frame_r[63:32] :
    (ra == crfb_pkg::ADDR_FRMLO) ? frame_r[31:0] :
    (ra == crfb_pkg::ADDR_STATE) ?
      {24'h0, st_r, startOk_r, violSeen_r, roll_r} : 32'h0;

  // Capture address phase; zero wait states always
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      rdata_r  <= '0;
    end else if (ce) begin
      wrPend_r <= addrPh && hwrite;
      wrAddr_r <= haddr[7:0];
      if (addrPh && !hwrite) rdata_r <= rdMux;
    end
  end

  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Control, mask and identifier writes
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_r  <= crfb_pkg::CTRL_RST;
      mask_r  <= '0;
      canId_r <= crfb_pkg::CANID_RST;
    end else if (ce) begin
      if (wrCtrl) ctrl_r <= hwdata[1:0];
      if (wrMask) mask_r <= hwdata[crfb_pkg::ST_W-1:0];
      if (wrId)   canId_r <= hwdata[10:0];
    end
  end

  // ***************************************************************
  // Interrupt status
  // ***************************************************************
  logic [crfb_pkg::ST_W-1:0] evt;
  logic [crfb_pkg::ST_W-1:0] clrBits;

  // Events of the frame just taken, and missed ticks
  always_comb begin
    evt = '0;
    evt[crfb_pkg::ST_SENT]  = txDone;
    evt[crfb_pkg::ST_VIOL]  = txDone && frame_r[56];
    evt[crfb_pkg::ST_IERR]  = txDone && frame_r[57];
    evt[crfb_pkg::ST_OVRUN] = tick && enable &&
                              st_r != crfb_pkg::CRFB_IDLE;
  end
  assign clrBits = wrStat ? hwdata[crfb_pkg::ST_W-1:0] : '0;

  // Set wins over write-one-to-clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) stat_r <= '0;
    else if (ce) stat_r <= (stat_r & ~clrBits) | evt;
  end

  assign irq = |(stat_r & mask_r);

endmodule

//--- tb_top.sv
// Self-checking bench for the frame builder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 40;  // Short period, brief run
  // ***************************************************************
  // Signals
  // ***************************************************************
  logic               clk, arst_n, ce, hsel, hwrite, hwFault;
  logic               supplyMvValid, txReady, irq, hreadyout, hresp;
  logic               txValid, rxCrcOk;
  logic [1:0]         htrans, supplyState;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic signed [23:0] anaMa;
  logic signed [15:0] digAmp;
  logic [15:0]        supplyMv;
  logic [3:0]         txDlc, stallCyc, expRoll;
  logic [10:0]        txId;
  logic [63:0]        txData, rxFrame;
  logic [7:0]         rxCount;
  int                 n_mismatch = 0, samples_checked = 0;
  crfb_top #(.PERIOD_CYC(PER)) dut_u (.clk(clk), .arst_n(arst_n), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .anaMa(anaMa), .digAmp(digAmp),
    .supplyMv(supplyMv), .supplyMvValid(supplyMvValid),
    .supplyState(supplyState), .hwFault(hwFault), .txValid(txValid),
    .txReady(txReady), .txId(txId), .txDlc(txDlc), .txData(txData),
    .irq(irq));
  crfb_can_model part_u (.clk(clk), .arst_n(arst_n), .stallCyc(stallCyc),
    .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxFrame(rxFrame), .rxCrcOk(rxCrcOk), .rxCount(rxCount));
  // Free running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Wait ran out: fail
  task automatic tmo();
    n_mismatch++;
    end_sim();
  endtask
  // One single AHB-Lite transfer, hsize left at halfword
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    int n;
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) tmo();
    r = hrdata;
  endtask
  // Wait for a frame, check counter and check byte
  task automatic nextFrame();
    logic [7:0] c0;
    int         n;
    c0 = rxCount;
    n  = 0;
    while (rxCount === c0 && n < 4 * PER) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4 * PER) tmo();
    chk("roll", rxFrame[63:60], expRoll);
    chk("crc ok", rxCrcOk, 1'b1);
    expRoll = (expRoll == 4'hF) ? 4'h1 : expRoll + 4'h1;
  endtask
  // Set inputs, check third frame
  task automatic fc(input logic signed [23:0] a, input logic signed [15:0] d,
                    input logic hw, input logic [3:0] lo,
                    input logic [23:0] eA, input logic [15:0] eD);
    anaMa   <= a;
    digAmp  <= d;
    hwFault <= hw;
    repeat (3) nextFrame();
    chk("byte0 low", rxFrame[59:56], lo);
    chk("analog", rxFrame[55:32], eA);
    chk("digital", rxFrame[31:8], {eD, 8'h00});
  endtask
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    {arst_n, hsel, hwrite, hwFault, supplyMvValid} = 5'h00;
    {htrans, haddr, hwdata, anaMa, digAmp, supplyMv} = '0;
    {ce, hsize, supplyState} = 6'h25;
    {stallCyc, expRoll} = '0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values and an unmapped place
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk("ctrl", rd, 32'h3);
    ahb(1'b0, 8'h08, 32'h0, rd);
    chk("mask", rd, 32'h0);
    ahb(1'b0, 8'h0C, 32'h0, rd);
    chk("id reg", rd, 32'h3C2);
    ahb(1'b1, 8'h1C, 32'hFFFFFFFF, rd);
    ahb(1'b0, 8'h1C, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    chk("id out", txId, 11'h3C2);
    $display("test regs done");
    // Supply out of range at start: no frames
    supplyMvValid <= 1'b1;
    supplyMv <= 16'd7799;
    repeat (3 * PER) @(posedge clk);
    supplyMv <= 16'd16201;
    repeat (3 * PER) @(posedge clk);
    chk("no frame", rxCount, 8'h00);
    supplyMv <= 16'd16200;
    nextFrame();
    $display("test startup done");
    // Codes, clamps and errors
    fc(24'sd0, 16'sd0, 1'b0, 4'h4, 24'h800000, 16'h8000);
    fc(24'sd1, 16'sd0, 1'b0, 4'h4, 24'h800001, 16'h8000);
    fc(-24'sd1, 16'sd0, 1'b0, 4'h4, 24'h7FFFFF, 16'h8000);
    fc(24'sd1500000, 16'sd1500, 1'b0, 4'h4, 24'h96E360, 16'h85DC);
    fc(-24'sd1500000, -16'sd1500, 1'b0, 4'h4, 24'h691CA0, 16'h7A24);
    fc(24'sd1600000, 16'sd1550, 1'b0, 4'h4, 24'h97A6B0, 16'h860E);
    fc(-24'sd1650000, -16'sd1650, 1'b0, 4'h6, 24'h685950, 16'h79F2);
    fc(24'sd1700001, 16'sd1700, 1'b0, 4'h6, 24'hFFFFFF, 16'h860E);
    fc(24'sd0, 16'sd0, 1'b1, 4'h6, 24'h800000, 16'h8000);
    supplyMvValid <= 1'b0;
    fc(24'sd0, 16'sd0, 1'b0, 4'hC, 24'h800000, 16'h8000);
    supplyMvValid <= 1'b1;
    $display("test codes done");
    // Violation edges with a slow partner
    stallCyc <= 4'h9;
    fc(24'sd100000, 16'sd144, 1'b0, 4'h4, 24'h8186A0, 16'h8090);
    fc(24'sd1000000, 16'sd1200, 1'b0, 4'h4, 24'h8F4240, 16'h84B0);
    fc(24'sd100000, 16'sd145, 1'b0, 4'h5, 24'h8186A0, 16'h8091);
    fc(-24'sd1000000, -16'sd1201, 1'b0, 4'h5, 24'h70BDC0, 16'h7B4F);
    ahb(1'b1, 8'h00, 32'h1, rd);
    fc(24'sd100000, 16'sd145, 1'b0, 4'h4, 24'h8186A0, 16'h0000);
    $display("test violation done");
    // Sticky status, mask and clear with frames stopped
    ahb(1'b1, 8'h00, 32'h0, rd);
    repeat (3 * PER) @(posedge clk);
    ahb(1'b0, 8'h04, 32'h0, rd);
    chk("status", rd, 32'h7);
    chk("irq masked", irq, 1'b0);
    ahb(1'b1, 8'h08, 32'h2, rd);
    ce <= 1'b0;
    @(negedge clk);
    chk("irq on", irq, 1'b1);
    ahb(1'b1, 8'h04, 32'h7, rd);
    ce <= 1'b1;
    chk("ce freeze", irq, 1'b1);
    ahb(1'b1, 8'h04, 32'h7, rd);
    ahb(1'b0, 8'h04, 32'h0, rd);
    chk("status clr", rd, 32'h0);
    chk("irq off", irq, 1'b0);
    $display("test irq done");
    end_sim();
  end
endmodule
